// ---- inc/acw_pkg.sv ----
/*
  Package for the transceiver configuration word block: field positions,
  reset value and rate division figures.
  Assumes a 50 MHz system clock and a host data bus of 16 bits.
*/
package acw_pkg;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int          CFG_WIDTH      = 16;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [15:0] CFG_USED_MASK  = 16'hFFF0;
  localparam logic        READY_RESET    = 1'b1;
  localparam int          BIT_PAR_INS    = 4;
  localparam int          BIT_LOOP_N     = 5;
  localparam int          BIT_RX1_CHK    = 6;
  localparam int          BIT_RX1_B9     = 7;
  localparam int          BIT_RX1_B10    = 8;
  localparam int          BIT_RX2_CHK    = 9;
  localparam int          BIT_RX2_B9     = 10;
  localparam int          BIT_RX2_B10    = 11;
  localparam int          BIT_PAR_INV    = 12;
  localparam int          BIT_TX_RATE    = 13;
  localparam int          BIT_RX_RATE    = 14;
  localparam int          BIT_WORD_LEN   = 15;

  // ----------------------------------------------------------------
  // Serial word figures
  // ----------------------------------------------------------------
  localparam logic [5:0]  WORD_BITS_LONG  = 6'h20;
  localparam logic [5:0]  WORD_BITS_SHORT = 6'h19;
  localparam logic [6:0]  DIV_HIGH_RATE   = 7'h0A;
  localparam logic [6:0]  DIV_LOW_RATE    = 7'h50;

endpackage : acw_pkg

// ---- logic/acw_config_word.sv ----
/*
  Configuration word register of a two receiver, one transmitter serial
  bus transceiver, with the field decode the serial logic consumes.
  Assumes the load strobe and data bus are synchronous to clk, and that
  the receivers, transmitter and buffer live outside and use the outputs.
*/
// Functional notes
// - Low load strobe captures bus bits 15 to 4
// - Lowest four bits ignored, never stored
// - Pin high forces parity into bit 32
// - Pin low: field picks data or parity
// - Loopback field low loops transmitter to receivers
// - Second receiver gets inverted loopback data
// - Transmitter keeps driving line during loopback
// - Bit six enables first receiver code check
// - First receiver matches bits nine and ten
// - Bit nine enables second receiver code check
// - Second receiver matches bits nine and ten
// - Parity sense: zero odd, one even
// - Transmit rate: divide by ten or eighty
// - Receive rate: divide by ten or eighty
// - Word length: thirty-two or twenty-five bits
// - Ready flag rises when buffer drains
module acw_config_word (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        config_load_strobe_n,
  input  wire logic [acw_pkg::CFG_WIDTH-1:0] data_bus,
  input  wire logic                        bit32_data_mode_pin_n,
  input  wire logic                        tx_serial_a,
  input  wire logic                        tx_serial_b,
  input  wire logic                        line_rx1_data,
  input  wire logic                        line_rx2_data,
  input  wire logic [1:0]                  rx1_code_bits,
  input  wire logic [1:0]                  rx2_code_bits,
  input  wire logic                        tx_last_word_done,
  input  wire logic                        tx_second_half_load,
  output logic [acw_pkg::CFG_WIDTH-1:0]    transceiver_configuration_word,
  output logic                             word_length_choice,
  output logic                             receive_rate_choice,
  output logic                             transmit_rate_choice,
  output logic                             parity_sense_invert,
  output logic                             parity_insert_enable,
  output logic                             parity_in_bit32,
  output logic                             loopback_test_n,
  output logic                             first_rx_code_check_on,
  output logic                             second_rx_code_check_on,
  output logic                             first_rx_bit9_code,
  output logic                             first_rx_bit10_code,
  output logic                             second_rx_bit9_code,
  output logic                             second_rx_bit10_code,
  output logic                             first_rx_accept,
  output logic                             second_rx_accept,
  output logic                             rx1_serial_in,
  output logic                             rx2_serial_in,
  output logic                             tx_line_a,
  output logic                             tx_line_b,
  output logic [6:0]                       tx_rate_divisor,
  output logic [6:0]                       rx_rate_divisor,
  output logic [5:0]                       word_bit_count,
  output logic                             transmit_buffer_empty_flag
);
  import acw_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shared by both rate fields
  function automatic logic [6:0] rate_div(input logic low_rate);
    rate_div = low_rate ? DIV_LOW_RATE : DIV_HIGH_RATE;
  endfunction

  // Code match used by both receivers
  function automatic logic code_ok(input logic chk_on, input logic [1:0] got,
                                   input logic b9, input logic b10);
    code_ok = !chk_on || (got[0] == b9 && got[1] == b10);
  endfunction

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic [CFG_WIDTH-1:0] cfg_r, cfg_nxt;
  logic                 ready_r, ready_nxt;

  // Capture while strobe low; unused bits are masked so they read zero
  always_comb begin
    cfg_nxt = cfg_r;
    if (!config_load_strobe_n) begin
      cfg_nxt = data_bus & CFG_USED_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit ready flag
  // ----------------------------------------------------------------
  // Drain event wins over a coincident load so a finished block is seen
  always_comb begin
    ready_nxt = ready_r;
    if (tx_second_half_load) begin
      ready_nxt = 1'b0;
    end
    if (tx_last_word_done) begin
      ready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_r <= READY_RESET;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign transceiver_configuration_word = cfg_r;
  assign word_length_choice      = cfg_r[BIT_WORD_LEN];
  assign receive_rate_choice     = cfg_r[BIT_RX_RATE];
  assign transmit_rate_choice    = cfg_r[BIT_TX_RATE];
  assign parity_sense_invert     = cfg_r[BIT_PAR_INV];
  assign parity_insert_enable    = cfg_r[BIT_PAR_INS];
  assign loopback_test_n         = cfg_r[BIT_LOOP_N];
  assign first_rx_code_check_on  = cfg_r[BIT_RX1_CHK];
  assign second_rx_code_check_on = cfg_r[BIT_RX2_CHK];
  assign first_rx_bit9_code      = cfg_r[BIT_RX1_B9];
  assign first_rx_bit10_code     = cfg_r[BIT_RX1_B10];
  assign second_rx_bit9_code     = cfg_r[BIT_RX2_B9];
  assign second_rx_bit10_code    = cfg_r[BIT_RX2_B10];

  // Pin open reads high via pull-up, which forces parity
  assign parity_in_bit32 = bit32_data_mode_pin_n | cfg_r[BIT_PAR_INS];

  // Rates and word length; change timing is the host's duty
  assign tx_rate_divisor = rate_div(cfg_r[BIT_TX_RATE]);
  assign rx_rate_divisor = rate_div(cfg_r[BIT_RX_RATE]);
  assign word_bit_count  = cfg_r[BIT_WORD_LEN] ? WORD_BITS_SHORT
                                               : WORD_BITS_LONG;

  // Source/destination acceptance
  assign first_rx_accept  = code_ok(cfg_r[BIT_RX1_CHK], rx1_code_bits,
                                    cfg_r[BIT_RX1_B9], cfg_r[BIT_RX1_B10]);
  assign second_rx_accept = code_ok(cfg_r[BIT_RX2_CHK], rx2_code_bits,
                                    cfg_r[BIT_RX2_B9], cfg_r[BIT_RX2_B10]);

  // Loopback data selector; one-rail taken from rail a alone of the two-rail pair
  assign rx1_serial_in = !cfg_r[BIT_LOOP_N] ? tx_serial_a : line_rx1_data;
  assign rx2_serial_in = !cfg_r[BIT_LOOP_N] ? ~tx_serial_a : line_rx2_data;

  // Line outputs never gated by test mode
  assign tx_line_a = tx_serial_a;
  assign tx_line_b = tx_serial_b;
  assign transmit_buffer_empty_flag = ready_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Ready flag steps: a half load marks the buffer busy, a drain empties it
  sequence s_half_loaded;
    tx_second_half_load && !tx_last_word_done;
  endsequence
  sequence s_buffer_busy;
    !transmit_buffer_empty_flag;
  endsequence
  sequence s_buffer_empty;
    transmit_buffer_empty_flag;
  endsequence

  chk_load_captures: assert property (@(posedge clk) disable iff (rst)
    !config_load_strobe_n |=> cfg_r == ($past(data_bus) & CFG_USED_MASK))
    else $error("load did not capture bus");
  chk_low_bits_zero: assert property (@(posedge clk) disable iff (rst)
    cfg_r[3:0] == 4'h0)
    else $error("unused bits stored");
  chk_parity_forced: assert property (@(posedge clk) disable iff (rst)
    bit32_data_mode_pin_n |-> parity_in_bit32)
    else $error("parity not forced with pin high");
  chk_parity_field: assert property (@(posedge clk) disable iff (rst)
    !bit32_data_mode_pin_n |-> parity_in_bit32 == cfg_r[BIT_PAR_INS])
    else $error("parity field ignored");
  chk_loop_rx1: assert property (@(posedge clk) disable iff (rst)
    !loopback_test_n |-> rx1_serial_in == tx_serial_a)
    else $error("receiver 1 loopback not from transmitter");
  chk_line_select: assert property (@(posedge clk) disable iff (rst)
    loopback_test_n |-> rx1_serial_in == line_rx1_data
                        && rx2_serial_in == line_rx2_data)
    else $error("line data not routed outside loopback");
  chk_loop_inverted: assert property (@(posedge clk) disable iff (rst)
    !loopback_test_n |-> rx2_serial_in != rx1_serial_in)
    else $error("receiver 2 loopback not inverted");
  chk_line_driven: assert property (@(posedge clk) disable iff (rst)
    tx_line_a == tx_serial_a && tx_line_b == tx_serial_b)
    else $error("transmitter line outputs not driven");
  chk_rx1_reject: assert property (@(posedge clk) disable iff (rst)
    (first_rx_code_check_on && rx1_code_bits[0] != first_rx_bit9_code)
      |-> !first_rx_accept)
    else $error("mismatched word accepted by rx1");
  chk_rx1_accept: assert property (@(posedge clk) disable iff (rst)
    (!first_rx_code_check_on
      || rx1_code_bits == {first_rx_bit10_code, first_rx_bit9_code}) |-> first_rx_accept)
    else $error("matching word refused by rx1");
  chk_rx2_reject: assert property (@(posedge clk) disable iff (rst)
    (second_rx_code_check_on
      && rx2_code_bits != {second_rx_bit10_code, second_rx_bit9_code}) |-> !second_rx_accept)
    else $error("mismatched word accepted by rx2");
  chk_rx2_accept: assert property (@(posedge clk) disable iff (rst)
    (!second_rx_code_check_on
      || rx2_code_bits == {second_rx_bit10_code, second_rx_bit9_code}) |-> second_rx_accept)
    else $error("matching word refused by rx2");
  chk_rate_divide: assert property (@(posedge clk) disable iff (rst)
    tx_rate_divisor == (transmit_rate_choice ? 7'h50 : 7'h0A))
    else $error("transmit divisor wrong");
  chk_rx_rate: assert property (@(posedge clk) disable iff (rst)
    rx_rate_divisor == (receive_rate_choice ? 7'h50 : 7'h0A))
    else $error("receive divisor wrong");
  chk_word_length: assert property (@(posedge clk) disable iff (rst)
    word_bit_count == (word_length_choice ? 6'h19 : 6'h20))
    else $error("word length wrong");
  chk_fields_hold: assert property (@(posedge clk) disable iff (rst)
    config_load_strobe_n |=> $stable(cfg_r))
    else $error("config changed without load");
  chk_ready_rises: assert property (@(posedge clk) disable iff (rst)
    tx_last_word_done |=> s_buffer_empty)
    else $error("ready flag not set after drain");
  chk_ready_falls: assert property (@(posedge clk) disable iff (rst)
    s_half_loaded |=> s_buffer_busy)
    else $error("ready flag not cleared after half load");

endmodule : acw_config_word

// ---- bench/acw_host_model.sv ----
/* Host model: drives the load strobe and the data bus of the
   configuration word block. Assumes clk and rst shared with it. */
module acw_host_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load_req,
  input  wire logic [15:0] load_word,
  input  wire logic        ready_flag,
  output logic             config_load_strobe_n,
  output logic [15:0]      data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Strobe and bus driver
  // ----------------------------------------------------------------
  // Idle bus flips every cycle so a stray capture never matches by luck
  // Loads wait for an empty transmit buffer, so a rate change is safe
  // No received words are consumed, so none need discarding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_load_strobe_n <= 1'b1;
      data_bus             <= 16'h5A5A;
    end else if (load_req && ready_flag) begin
      config_load_strobe_n <= 1'b0;
      data_bus             <= load_word;
    end else begin
      config_load_strobe_n <= 1'b1;
      data_bus             <= ~data_bus;
    end
  end
endmodule // acw_host_model

// ---- bench/tb_acw_config_word.sv ----
/* Self-checking bench: reset, then table of loads, hold, back to back,
   ready flag and mid-run reset cases. Assumes the host model is compiled first. */
module tb_acw_config_word;
  timeunit 1ns;
  timeprecision 1ps;
  import acw_pkg::*;
  // ----------------------------------------------------------------
  // Signals and table
  // ----------------------------------------------------------------
  logic        clk = 0, rst = 1, req = 0, pin_n = 1, tsa = 0;
  logic        l1 = 0, l2 = 0, done = 0, half = 0, stb_n;
  logic [1:0]  c1 = 0, c2 = 0;
  logic [15:0] word = 0, bus, cfg, w;
  logic [31:0] r;
  logic [6:0]  txd, rxd;
  logic [5:0]  wbc;
  wire  [11:0] fld;
  wire  [7:0]  o;
  int          n_mismatch = 0, comparisons = 0;
  // Row: word, then pin_n, tx data, line 1, line 2, rx1 codes, rx2 codes,
  // then expected bit-32 parity, rx1 in, rx2 in, line a, line b, accept 1, accept 2
  localparam logic [31:0] ROWS [6] = '{32'hFFFFDF5B, 32'h000F602B, 32'h0A403615,
                                       32'h5190486B, 32'hA1C01C17, 32'h0E20E16A};
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  acw_host_model i_host (.clk(clk), .rst(rst), .load_req(req), .load_word(word),
    .ready_flag(o[0]), .config_load_strobe_n(stb_n), .data_bus(bus));
  acw_config_word i_dut (.clk(clk), .rst(rst), .config_load_strobe_n(stb_n),
    .data_bus(bus), .bit32_data_mode_pin_n(pin_n), .tx_serial_a(tsa),
    .tx_serial_b(~tsa), .line_rx1_data(l1), .line_rx2_data(l2),
    .rx1_code_bits(c1), .rx2_code_bits(c2), .tx_last_word_done(done),
    .tx_second_half_load(half), .transceiver_configuration_word(cfg),
    .word_length_choice(fld[11]), .receive_rate_choice(fld[10]),
    .transmit_rate_choice(fld[9]), .parity_sense_invert(fld[8]),
    .second_rx_bit10_code(fld[7]), .second_rx_bit9_code(fld[6]),
    .second_rx_code_check_on(fld[5]), .first_rx_bit10_code(fld[4]),
    .first_rx_bit9_code(fld[3]), .first_rx_code_check_on(fld[2]),
    .loopback_test_n(fld[1]), .parity_insert_enable(fld[0]),
    .parity_in_bit32(o[7]), .rx1_serial_in(o[6]), .rx2_serial_in(o[5]),
    .tx_line_a(o[4]), .tx_line_b(o[3]), .first_rx_accept(o[2]),
    .second_rx_accept(o[1]), .transmit_buffer_empty_flag(o[0]),
    .tx_rate_divisor(txd), .rx_rate_divisor(rxd), .word_bit_count(wbc));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request one load; the host strobes a cycle later, capture the next
  task automatic load(input logic [15:0] v);
    @(posedge clk);
    req <= 1'b1;
    word <= v;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset cfg", cfg, 16'h0000);
    check("reset ready", o[0], 1'b1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      w = r[31:16];
      @(posedge clk);
      {pin_n, tsa, l1, l2, c1, c2} <= r[15:8];
      load(w);
      check("cfg", cfg, w & 16'hFFF0);
      check("fields", fld, w[15:4]);
      check("paths", o[7:1], r[6:0]);
      check("rates", {txd, rxd, wbc}, {w[13] ? 7'h50 : 7'h0A,
        w[14] ? 7'h50 : 7'h0A, w[15] ? 6'h19 : 6'h20});
    end
    $display("test table done");
    load(16'h3C35);
    repeat (6) @(negedge clk);
    check("hold", cfg, 16'h3C30);
    $display("test hold done");
    @(posedge clk);
    req <= 1'b1;
    word <= 16'h1111;
    @(posedge clk);
    word <= 16'hC0A5;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("back to back", cfg, 16'hC0A0);
    $display("test back to back done");
    @(posedge clk);
    half <= 1'b1;
    @(posedge clk);
    half <= 1'b0;
    @(negedge clk);
    check("ready low", o[0], 1'b0);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    check("ready high", o[0], 1'b1);
    // Coincident drain and half load: the drain must win
    @(posedge clk);
    half <= 1'b1;
    done <= 1'b1;
    @(posedge clk);
    half <= 1'b0;
    done <= 1'b0;
    @(negedge clk);
    check("ready both", o[0], 1'b1);
    $display("test ready done");
    // Busy flag and loaded word must both fall back under a mid-run reset
    @(posedge clk);
    half <= 1'b1;
    @(posedge clk);
    half <= 1'b0;
    @(negedge clk);
    check("busy before reset", o[0], 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check("mid reset", {cfg, fld}, 28'h0);
    check("mid reset ready", o[0], 1'b1);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // tb_acw_config_word
